//--- mcrpt_top.sv
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "mcrpt_defs.svh"

//
// Overview of operation
// - one-step enable turns one-step timestamping on
// - transparent-clock mode with one-step enabled turns on correction field updates
// - timer is correction; timestamp added to correction
// - timers and timestamps use correction-field format
// - trim is fixed point, three fractional bits
// - trim resets to 705 decimal
// - lane width 32 ten-lane, 80 four-lane
// - one core clock drives lanes, MAC, control
// - independent path resets, separate core and lane
// - resets assert async, release via synchronisers
// - global resets all; datapath resets own path
// - sync mode tx out clock sources both
// - switchable mode uses ten-lane clocking
// - optional single receive lane clock, buffered raw
module mcrpt_top
  import mcrpt_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire mcrpt_pkg::mcrpt_addr_t paddr,
  input  wire mcrpt_pkg::mcrpt_data_t pwdata,
  output logic                    pready,
  output logic                    pslverr,
  output mcrpt_pkg::mcrpt_data_t  prdata,
  // transmit precision-time packet event
  input  wire logic               ptpStart,
  input  wire mcrpt_pkg::mcrpt_corr_t txTimer,
  input  wire mcrpt_pkg::mcrpt_corr_t corrIn,
  output logic                    tsValid,
  output mcrpt_pkg::mcrpt_corr_t  twoStepTs,
  output mcrpt_pkg::mcrpt_corr_t  oneStepTs,
  output mcrpt_pkg::mcrpt_corr_t  corrOut,
  output logic                    corrUpdate,
  // synchronised resets
  output logic                    xcvrTxReset,
  output logic                    xcvrRxReset,
  output logic                    txCoreReset,
  output logic                    txLaneReset,
  output logic                    rxCoreReset,
  output mcrpt_pkg::mcrpt_lanes_t rxLaneReset,
  // clocking arrangement
  output logic                    rxUserFromRxOut,
  output logic                    rxLaneClockShared,
  output logic                    xcvrBufferEnable,
  output logic [6:0]              laneDataWidth
);
  import mcrpt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [`MCRPT_CTRL_W-1:0] ctrl_r;      // software view of control
  logic [`MCRPT_CTRL_W-1:0] cfgTx_r;     // tx-side active settings
  logic [`MCRPT_CTRL_W-1:0] cfgRx_r;     // rx-side active settings
  mcrpt_trim_t              trim_r;      // one-step latency trim
  logic [`MCRPT_RST_W-1:0]  rstCtl_r;    // software reset requests
  mcrpt_data_t              prdata_r;    // read data register
  logic                     pslverr_r;   // error flag for access phase
  mcrpt_corr_t              twoStep_r;   // captured two-step stamp
  mcrpt_corr_t              oneStep_r;   // trimmed one-step stamp
  mcrpt_corr_t              corr_r;      // updated correction field
  logic                     tsValid_r;   // one cycle per packet
  logic                     corrUpd_r;   // correction was rewritten
  mcrpt_corr_t              oneStepNxt;  // stamp with trim applied
  mcrpt_corr_t              trimCorr;    // trim in correction format
  mcrpt_sel_t               setupSel;    // decode of current address
  logic                     setupPhase;  // apb setup cycle
  logic                     wrStrobe;    // apb write takes effect
  logic                     txPathRst;   // tx datapath reset request
  logic                     rxPathRst;   // rx datapath reset request
  mcrpt_lanes_t             rxLaneReq;   // per-lane reset requests

  mcrpt_rst_if rstBus ();

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by read and write
  function automatic mcrpt_sel_t decodeAddr(input mcrpt_addr_t addr);
    mcrpt_sel_t sel;
    sel = MCRPT_SEL_NONE;
    unique case (addr)
      `MCRPT_OFS_CTRL:   sel = MCRPT_SEL_CTRL;
      `MCRPT_OFS_TRIM:   sel = MCRPT_SEL_TRIM;
      `MCRPT_OFS_RSTCTL: sel = MCRPT_SEL_RSTCTL;
      `MCRPT_OFS_STATUS: sel = MCRPT_SEL_STATUS;
      `MCRPT_OFS_TSLO:   sel = MCRPT_SEL_TSLO;
      `MCRPT_OFS_TSHI:   sel = MCRPT_SEL_TSHI;
      default:           sel = MCRPT_SEL_NONE;
    endcase
    return sel;
  endfunction

  assign setupSel   = decodeAddr(paddr);
  assign setupPhase = psel & ~penable;
  assign wrStrobe   = psel & penable & pwrite;

  // zero-wait slave: every access phase completes at once
  assign pready  = 1'b1;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // control register write
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ctrl_r <= `MCRPT_CTRL_RST;
    else if (wrStrobe && setupSel == MCRPT_SEL_CTRL)
      ctrl_r <= pwdata[`MCRPT_CTRL_W-1:0];
  end

  // latency trim write, defaults to normal-mode value
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      trim_r <= `MCRPT_TRIM_RST;
    else if (wrStrobe && setupSel == MCRPT_SEL_TRIM)
      trim_r <= pwdata[`MCRPT_TRIM_W-1:0];
  end

  // reset requests come out of reset all asserted
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rstCtl_r <= `MCRPT_RSTCTL_RST;
    else if (wrStrobe && setupSel == MCRPT_SEL_RSTCTL)
      rstCtl_r <= pwdata[`MCRPT_RST_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and error, prepared in the setup cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (setupPhase)
    begin
      pslverr_r <= (setupSel == MCRPT_SEL_NONE);
      unique case (setupSel)
        MCRPT_SEL_CTRL:
          prdata_r <= {26'h0, ctrl_r};
        MCRPT_SEL_TRIM:
          prdata_r <= {21'h0, trim_r};
        MCRPT_SEL_RSTCTL:
          prdata_r <= {16'h0, rstCtl_r};
        MCRPT_SEL_STATUS:  // live synchronised resets
          prdata_r <= {19'h0, rstBus.syncRst};
        MCRPT_SEL_TSLO:
          prdata_r <= oneStep_r[31:0];
        MCRPT_SEL_TSHI:
          prdata_r <= oneStep_r[63:32];
        MCRPT_SEL_NONE:
          prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset tree: global, datapath, then core and lane per path
  assign txPathRst = rstCtl_r[`MCRPT_RST_GLOBAL]
                   | rstCtl_r[`MCRPT_RST_TXDP];
  assign rxPathRst = rstCtl_r[`MCRPT_RST_GLOBAL]
                   | rstCtl_r[`MCRPT_RST_RXDP];
  assign rxLaneReq = {`MCRPT_RX_LANES{rxPathRst}}
                   | rstCtl_r[`MCRPT_RST_W-1:`MCRPT_RST_RXLANE_LO];

  // core and lane requests kept apart inside each path
  assign rstBus.req = {rxLaneReq,
                       rxPathRst | rstCtl_r[`MCRPT_RST_RXCORE],
                       txPathRst | rstCtl_r[`MCRPT_RST_TXLANE],
                       txPathRst | rstCtl_r[`MCRPT_RST_TXCORE]};

  // async assert, clocked release, on the shared core clock
  mcrpt_rst_sync u_sync
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .rstBus  (rstBus)
  );

  assign txCoreReset = rstBus.syncRst[0];
  assign txLaneReset = rstBus.syncRst[1];
  assign rxCoreReset = rstBus.syncRst[2];
  assign rxLaneReset = rstBus.syncRst[`MCRPT_NRST-1:3];
  // transceivers follow their datapath and the global request
  assign xcvrTxReset = rstBus.syncRst[1];
  assign xcvrRxReset = &rstBus.syncRst[`MCRPT_NRST-1:3];

  ////////////////////////////////////////////////////////////////////////////
  // reset-only settings: tx copy follows only while tx core is held
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cfgTx_r <= `MCRPT_CTRL_RST;
    else if (txCoreReset)
      cfgTx_r <= ctrl_r;
  end

  // rx copy follows only while rx core is held
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cfgRx_r <= `MCRPT_CTRL_RST;
    else if (rxCoreReset)
      cfgRx_r <= ctrl_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clocking arrangement selects
  // sync mode: tx out clock feeds rx user clock as well
  assign rxUserFromRxOut = cfgRx_r[`MCRPT_CTRL_ASYNCCLK];
  // switchable mode keeps one clock per lane, as ten-lane does
  assign rxLaneClockShared = cfgRx_r[`MCRPT_CTRL_ONERXCLK]
                           & ~cfgRx_r[`MCRPT_CTRL_SWITCHABLE];
  // a shared lane clock needs the transceiver buffer in raw mode
  assign xcvrBufferEnable = rxLaneClockShared;

  // lane datapath width per lane configuration
  assign laneDataWidth = (cfgTx_r[`MCRPT_CTRL_FOURLANE] &
                          ~cfgTx_r[`MCRPT_CTRL_SWITCHABLE])
                       ? `MCRPT_WIDTH_FOUR_LANE
                       : `MCRPT_WIDTH_TEN_LANE;

  ////////////////////////////////////////////////////////////////////////////
  // timestamp path, all on the core clock with control port
  // trim bits [10:3] ns, [2:0] eighths, aligned to frac field
  assign trimCorr = {40'h0, trim_r, 13'h0000};

  // one-step stamp sits trim later than the two-step capture
  assign oneStepNxt = txTimer + trimCorr;

  // capture stamps on each packet start, held by tx core reset
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      twoStep_r <= 64'h0;
      oneStep_r <= 64'h0;
      tsValid_r <= 1'b0;
    end
    else if (txCoreReset)
    begin
      twoStep_r <= 64'h0;
      oneStep_r <= 64'h0;
      tsValid_r <= 1'b0;
    end
    else
    begin
      tsValid_r <= ptpStart;
      if (ptpStart)
      begin
        twoStep_r <= txTimer;
        // one-step stamp only when one-step is enabled
        oneStep_r <= cfgTx_r[`MCRPT_CTRL_ONESTEP]
                   ? oneStepNxt : 64'h0;
      end
    end
  end

  // correction field: timer taken as correction, stamp added
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      corr_r    <= 64'h0;
      corrUpd_r <= 1'b0;
    end
    else if (txCoreReset)
    begin
      corr_r    <= 64'h0;
      corrUpd_r <= 1'b0;
    end
    else if (ptpStart)
    begin
      // only in transparent mode with one-step on
      if (cfgTx_r[`MCRPT_CTRL_TCMODE] &&
          cfgTx_r[`MCRPT_CTRL_ONESTEP])
      begin
        // incoming field already has the rx stamp removed
        corr_r    <= corrIn + oneStepNxt;
        corrUpd_r <= 1'b1;
      end
      else
      begin
        corr_r    <= corrIn;                     // pass unchanged
        corrUpd_r <= 1'b0;
      end
    end
    else
      corrUpd_r <= 1'b0;
  end

  // registered timestamp outputs
  assign tsValid    = tsValid_r;
  assign twoStepTs  = twoStep_r;
  assign oneStepTs  = oneStep_r;
  assign corrOut    = corr_r;
  assign corrUpdate = corrUpd_r;

endmodule

//--- mcrpt_defs.svh
`ifndef MCRPT_DEFS_SVH
`define MCRPT_DEFS_SVH

// register byte offsets
`define MCRPT_OFS_CTRL        8'h00
`define MCRPT_OFS_TRIM        8'h04
`define MCRPT_OFS_RSTCTL      8'h08
`define MCRPT_OFS_STATUS      8'h0c
`define MCRPT_OFS_TSLO        8'h10
`define MCRPT_OFS_TSHI        8'h14

// control register field positions
`define MCRPT_CTRL_ONESTEP    0
`define MCRPT_CTRL_TCMODE     1
`define MCRPT_CTRL_FOURLANE   2
`define MCRPT_CTRL_ASYNCCLK   3
`define MCRPT_CTRL_ONERXCLK   4
`define MCRPT_CTRL_SWITCHABLE 5
`define MCRPT_CTRL_W          6

// reset control field positions
`define MCRPT_RST_GLOBAL      0
`define MCRPT_RST_TXDP        1
`define MCRPT_RST_RXDP        2
`define MCRPT_RST_TXCORE      3
`define MCRPT_RST_TXLANE      4
`define MCRPT_RST_RXCORE      5
`define MCRPT_RST_RXLANE_LO   6
`define MCRPT_RST_W           16

// reset values
`define MCRPT_CTRL_RST        6'h00
`define MCRPT_TRIM_RST        11'h2c1
`define MCRPT_RSTCTL_RST      16'hffff

// lane counts and lane data widths
`define MCRPT_RX_LANES        10
`define MCRPT_WIDTH_TEN_LANE  7'h20
`define MCRPT_WIDTH_FOUR_LANE 7'h50

// trim width and its alignment into correction-field format
`define MCRPT_TRIM_W          11
`define MCRPT_TRIM_SHIFT      13

// number of internal reset domains and synchroniser depth
`define MCRPT_NRST            13
`define MCRPT_SYNC_STAGES     2

`endif

//--- mcrpt_pkg.sv
package mcrpt_pkg;
  // correction-field format: ns in [63:16], fractional ns in [15:0]
  typedef logic [63:0] mcrpt_corr_t;
  // one-step latency trim, [10:3] ns and [2:0] eighths of a ns
  typedef logic [10:0] mcrpt_trim_t;
  // apb address and data
  typedef logic [7:0]  mcrpt_addr_t;
  typedef logic [31:0] mcrpt_data_t;
  // per-lane receive vector
  typedef logic [9:0]  mcrpt_lanes_t;
  // decoded register select
  typedef enum {
    MCRPT_SEL_CTRL,
    MCRPT_SEL_TRIM,
    MCRPT_SEL_RSTCTL,
    MCRPT_SEL_STATUS,
    MCRPT_SEL_TSLO,
    MCRPT_SEL_TSHI,
    MCRPT_SEL_NONE
  } mcrpt_sel_t;
endpackage

//--- mcrpt_rst_if.sv
`timescale 1ns/1ps
`include "mcrpt_defs.svh"

// reset requests in, synchronised resets out
interface mcrpt_rst_if;
  logic [`MCRPT_NRST-1:0] req;     // asynchronous reset requests
  logic [`MCRPT_NRST-1:0] syncRst; // asserted at once, released on clock

  modport src
  (
    output req,
    input  syncRst
  );
  modport sync
  (
    input  req,
    output syncRst
  );
endinterface

//--- mcrpt_rst_sync.sv
`timescale 1ns/1ps
`include "mcrpt_defs.svh"

module mcrpt_rst_sync
(
  input  wire logic   clk_sys,
  input  wire logic   rst,
  mcrpt_rst_if.sync   rstBus
);

  ////////////////////////////////////////////////////////////////////////////
  // one synchroniser per reset domain
  genvar gi;
  generate
    for (gi = 0; gi < `MCRPT_NRST; gi = gi + 1)
    begin : g_sync
      logic                          arst;   // combined async source
      logic [`MCRPT_SYNC_STAGES-1:0] stage_r; // shift chain, first is meta

      assign arst = rst | rstBus.req[gi];

      // asserts at once, releases after the chain fills with zeros
      always_ff @(posedge clk_sys or posedge arst)
      begin
        if (arst)
          stage_r <= {`MCRPT_SYNC_STAGES{1'b1}};
        else
          stage_r <= {stage_r[`MCRPT_SYNC_STAGES-2:0], 1'b0};
      end

      // only the last stage leaves the chain
      assign rstBus.syncRst[gi] = stage_r[`MCRPT_SYNC_STAGES-1];
    end
  endgenerate

endmodule

//--- mcrpt_assertions.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////
// watches the stamping, reset and clocking outputs of the top
module mcrpt_chk
  import mcrpt_pkg::*;
(
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   ptpStart,
  input wire mcrpt_pkg::mcrpt_corr_t txTimer,
  input wire mcrpt_pkg::mcrpt_corr_t corrIn,
  input wire logic                   tsValid,
  input wire mcrpt_pkg::mcrpt_corr_t twoStepTs,
  input wire mcrpt_pkg::mcrpt_corr_t oneStepTs,
  input wire mcrpt_pkg::mcrpt_corr_t corrOut,
  input wire logic                   corrUpdate,
  input wire logic                   txCoreReset,
  input wire logic                   rxCoreReset,
  input wire mcrpt_pkg::mcrpt_lanes_t rxLaneReset,
  input wire logic                   xcvrRxReset,
  input wire logic                   rxLaneClockShared,
  input wire logic                   xcvrBufferEnable,
  input wire logic [6:0]             laneDataWidth
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // packet accepted, then stamp of the timer seen at that edge
  sequence s_take;
    ptpStart && !txCoreReset;
  endsequence
  sequence s_stamp;
    tsValid && (twoStepTs == $past(txTimer));
  endsequence
  a_stamp_follows: assert property (s_take |=> s_stamp)
    else $error("stamp missing after packet start");
  a_stamp_refused: assert property (!(ptpStart && !txCoreReset)
    |=> !tsValid) else $error("stamp without accepted start");
  a_corr_added: assert property (corrUpdate |-> tsValid &&
    corrOut == $past(corrIn) + oneStepTs) else $error("bad corr sum");
  a_corr_kept: assert property (tsValid && !corrUpdate |->
    corrOut == $past(corrIn)) else $error("corr changed");
  a_trim_fixed: assert property (tsValid && oneStepTs != 64'h0 |->
    ((oneStepTs - twoStepTs) & 64'h1fff) == 64'h0 &&
    (oneStepTs - twoStepTs) < 64'h100_0000) else $error("bad trim");
  a_rx_and: assert property (xcvrRxReset == &rxLaneReset)
    else $error("rx datapath reset mismatch");
  a_buffer_shared: assert property (xcvrBufferEnable ==
    rxLaneClockShared) else $error("buffer enable mismatch");
  a_width_legal: assert property (laneDataWidth == 7'h20 ||
    laneDataWidth == 7'h50) else $error("bad lane width");
  a_tx_sync_rel: assert property ($fell(txCoreReset) |->
    $past(txCoreReset, 2)) else $error("tx release too fast");
  a_rx_sync_rel: assert property ($fell(rxCoreReset) |->
    $past(rxCoreReset, 2)) else $error("rx release too fast");
  a_reset_async: assert property (disable iff (1'b0) rst |->
    txCoreReset && rxCoreReset && (&rxLaneReset))
    else $error("reset not asserted");
endmodule
bind mcrpt_top mcrpt_chk u_chk (.clk_sys, .rst, .ptpStart, .txTimer,
  .corrIn, .tsValid, .twoStepTs, .oneStepTs, .corrOut, .corrUpdate,
  .txCoreReset, .rxCoreReset, .rxLaneReset, .xcvrRxReset,
  .rxLaneClockShared, .xcvrBufferEnable, .laneDataWidth);

//--- mcrpt_ptp_src.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////
// user logic handing precision-time packets to the transmit side
module mcrpt_ptp_src
  import mcrpt_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   sendReq,
  input  wire mcrpt_pkg::mcrpt_corr_t timer,
  input  wire mcrpt_pkg::mcrpt_corr_t rxStamp,
  input  wire mcrpt_pkg::mcrpt_corr_t origCorr,
  output logic                        ptpStart,
  output mcrpt_pkg::mcrpt_corr_t      txTimer,
  output mcrpt_pkg::mcrpt_corr_t      corrIn
);
  initial
  begin
    ptpStart = 1'b0;
    txTimer  = 64'h0;
    corrIn   = 64'h0;
  end
  // one start pulse per request; lines toggle between packets
  always @(posedge clk_sys)
  begin
    ptpStart <= sendReq;
    if (sendReq)
    begin
      txTimer <= timer;              // correction format
      corrIn  <= origCorr - rxStamp; // rx stamp taken off
    end
    else
    begin
      txTimer <= ~txTimer;           // no stale value
      corrIn  <= ~corrIn;
    end
  end
endmodule

//--- test_mac_clock_reset_ptp_tx_cfg.sv
`timescale 1ns/1ps
module test_mac_clock_reset_ptp_tx_cfg;
  import mcrpt_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sendReq = 1'b0, pready, pslverr, tsValid;
  logic corrUpdate, xcvrTxReset, xcvrRxReset, txCoreReset;
  logic txLaneReset, rxCoreReset, rxUserFromRxOut;
  logic rxLaneClockShared, xcvrBufferEnable, ptpStart;
  logic [6:0] laneDataWidth;
  mcrpt_addr_t paddr = 8'h00;
  mcrpt_data_t pwdata = 32'h0, prdata, rdat;
  mcrpt_corr_t tm = 64'h0, st = 64'h0, og = 64'h0, txTimer, corrIn;
  mcrpt_corr_t twoStepTs, oneStepTs, corrOut;
  mcrpt_lanes_t rxLaneReset;
  logic err;
  int badCount = 0, nCompared = 0, cyc = 0;
  // one shared core clock, no reconfiguration clock
  always #12.5 clk_sys = ~clk_sys;
  mcrpt_top dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .ptpStart, .txTimer, .corrIn,
    .tsValid, .twoStepTs, .oneStepTs, .corrOut, .corrUpdate,
    .xcvrTxReset, .xcvrRxReset, .txCoreReset, .txLaneReset,
    .rxCoreReset, .rxLaneReset, .rxUserFromRxOut, .rxLaneClockShared,
    .xcvrBufferEnable, .laneDataWidth);
  mcrpt_ptp_src src (.clk_sys, .sendReq, .timer(tm), .rxStamp(st),
    .origCorr(og), .ptpStart, .txTimer, .corrIn);
  ////////////////////////////////////////////////////////////////////
  task completeRun;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      badCount++;
      completeRun();
    end
  end
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    nCompared++;
    if (g !== e)
    begin
      badCount++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, waits on pready
  task apb(input logic w, input mcrpt_addr_t a, input mcrpt_data_t d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // ends as soon as pready is high; the hang guard ends it otherwise
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input mcrpt_addr_t a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  // set controls under reset, then release all resets
  task cfg(input logic [5:0] c, input logic [10:0] tr);
    apb(1'b1, 8'h08, 32'hffff);
    apb(1'b1, 8'h00, {26'h0, c});
    apb(1'b1, 8'h04, {21'h0, tr});
    apb(1'b1, 8'h08, 32'h0);
    repeat (3) @(posedge clk_sys);
    rd(8'h0c, 32'h0, "status");
  endtask
  // one packet through the source model, result checked
  task pkt(input logic [63:0] t, s, o, input logic [10:0] tr,
           input logic one, tc);
    logic [63:0] e1, ec;
    e1 = one ? t + ({53'h0, tr} << 13) : 64'h0;
    ec = (one && tc) ? o - s + e1 : o - s;
    @(posedge clk_sys);
    sendReq <= 1'b1;
    tm <= t;
    st <= s;
    og <= o;
    @(posedge clk_sys);
    sendReq <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("tsValid", 64'h1, {63'h0, tsValid});
    chk("twoStep", t, twoStepTs);
    chk("oneStep", e1, oneStepTs);
    chk("corrOut", ec, corrOut);
    chk("corrUpd", {63'h0, one && tc}, {63'h0, corrUpdate});
  endtask
  ////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(8'h00, 32'h0, "ctrl");
    rd(8'h04, 32'h2c1, "trim");
    rd(8'h08, 32'hffff, "rstctl");
    rd(8'h0c, 32'h1fff, "status");
    @(posedge clk_sys);
    sendReq <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sendReq <= 1'b0;
    chk("refused", 64'h0, {63'h0, tsValid});
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 64'h1, {63'h0, err});
    chk("unmapped", 64'h0, {32'h0, rdat});
    $display("reset test done");
  endtask
  task t_stamp;
    cfg(6'h00, 11'h2c1);
    pkt(64'h1234_5000, 64'h200, 64'h9000, 11'h2c1, 1'b0, 1'b0);
    cfg(6'h01, 11'h2c1);
    pkt(64'h7700_0000, 64'h100, 64'h5000, 11'h2c1, 1'b1, 1'b0);
    rd(8'h10, 32'h7758_2000, "tslo");
    rd(8'h14, 32'h0, "tshi");
    cfg(6'h03, 11'h322);
    pkt(64'h10_0000, 64'h3000, 64'h8000, 11'h322, 1'b1, 1'b1);
    pkt(64'h22_0007, 64'h10, 64'hffff, 11'h322, 1'b1, 1'b1);
    $display("stamp test done");
  endtask
  task t_clock;
    logic [5:0] v;
    apb(1'b1, 8'h08, 32'hffff);
    for (int i = 0; i < 4; i++)
    begin
      v = (i == 3) ? 6'h30 : (6'h04 << i);
      apb(1'b1, 8'h00, {26'h0, v});
      repeat (3) @(posedge clk_sys);
      #1;
      chk("width", v[2] ? 7'h50 : 7'h20, laneDataWidth);
      chk("rxUser", v[3], rxUserFromRxOut);
      chk("shared", v[4] && !v[5], rxLaneClockShared);
      chk("buffer", v[4] && !v[5], xcvrBufferEnable);
    end
    $display("clock test done");
  endtask
  task t_resets;
    logic [15:0] v;
    apb(1'b1, 8'h08, 32'h20);
    repeat (3) @(posedge clk_sys);
    chk("rxCore", 64'h1, {63'h0, rxCoreReset});
    chk("txCore", 64'h0, {63'h0, txCoreReset});
    for (int i = 0; i < 3; i++)
    begin
      v = 16'h1 << i;
      apb(1'b1, 8'h08, {16'h0, v});
      repeat (3) @(posedge clk_sys);
      #1;
      chk("xcvrTx", v[0] | v[1], xcvrTxReset);
      chk("xcvrRx", v[0] | v[2], xcvrRxReset);
      chk("txLane", v[0] | v[1], txLaneReset);
      chk("rxLane", {10{v[0] | v[2]}}, rxLaneReset);
    end
    $display("reset path test done");
  endtask
  initial
  begin
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_stamp();
    t_clock();
    t_resets();
    completeRun();
  end
endmodule
